//--- rtl/hqpe_pkg.sv
// Shared constants and carriers for the queue pair engine
package hqpe_pkg;
	// Fixed slot sizes in bytes and the memory beat width
	localparam int CMD_BYTES = 64;
	localparam int CPL_BYTES = 16;
	localparam int BEAT_BYTES = 8;
	localparam int BEATS_PER_CMD = CMD_BYTES / BEAT_BYTES;
	localparam int CMD_SHIFT = $clog2(CMD_BYTES);
	localparam int CPL_SHIFT = $clog2(CPL_BYTES);
	// Identifier, index and address widths
	localparam int QID_W = 16;
	localparam int IDX_W = 16;
	localparam int ADDR_W = 64;
	localparam int DATA_W = BEAT_BYTES * 8;
	localparam int STAT_W = 15;
	// Default data buffer depth in beats
	localparam int FIFO_DEPTH = 16;
	// Admin queue identifier
	localparam logic [QID_W-1:0] ADMIN_QID = 16'h0000;
	// Broadcast namespace identifier
	localparam logic [31:0] NSID_BCAST = 32'h0FFFFFFF;
	// Namespace identifier sits in the upper half of the first beat
	localparam int NSID_LSB = 32;
	// Completion entry field positions
	localparam int CPL_W = CPL_BYTES * 8;
	localparam int CPL_SQHD_LSB = 64;
	localparam int CPL_SQID_LSB = 80;
	localparam int CPL_CID_LSB = 96;
	localparam int CPL_PHASE_BIT = 112;
	localparam int CPL_STAT_LSB = 113;
	// Reset value of the phase marker written on the first pass
	localparam logic PHASE_RESET = 1'b1;

	// Doorbell write as delivered by the bus front end
	typedef struct packed {
		logic is_result;
		logic [QID_W-1:0] qid;
		logic [IDX_W-1:0] value;
	} hqpe_bell_type;

	// Queue creation request
	typedef struct packed {
		logic is_result;
		logic [QID_W-1:0] qid;
		logic [ADDR_W-1:0] base;
		logic [IDX_W-1:0] last_slot;
		logic [QID_W-1:0] result_qid;
	} hqpe_qcfg_type;

	// One fetched command beat on its way to the executor
	typedef struct packed {
		logic [QID_W-1:0] sqid;
		logic first;
		logic last;
		logic bcast;
		logic [DATA_W-1:0] data;
	} hqpe_beat_type;

	// Completion handed back by the executor
	typedef struct packed {
		logic [QID_W-1:0] sqid;
		logic [15:0] cid;
		logic [STAT_W-1:0] status;
	} hqpe_cpl_type;
endpackage : hqpe_pkg

//--- rtl/hqpe_fifo.sv
`timescale 1ns/1ps
// Flip-flop FIFO with valid and ready on both sides
module hqpe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [$clog2(DEPTH):0] count_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage entries
	logic [PW:0] wr_q; // Write pointer with lap bit
	logic [PW:0] rd_q; // Read pointer with lap bit
	logic push_w;
	logic pop_w;
	logic full_w;
	logic empty_w;

	assign empty_w = (wr_q == rd_q);
	assign full_w = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
	assign push_w = in_valid_i && !full_w;
	assign pop_w = out_ready_i && !empty_w;
	assign in_ready_o = !full_w;
	assign out_valid_o = !empty_w;
	assign out_data_o = mem_q[rd_q[PW-1:0]];
	assign count_o = wr_q - rd_q;

	// Pointer update
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push_w) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop_w) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	// Entry write
	always_ff @(posedge core_clk_i) begin
		if (push_w) begin
			mem_q[wr_q[PW-1:0]] <= in_data_i;
		end
	end
endmodule : hqpe_fifo

//--- rtl/hqpe_engine.sv
`timescale 1ns/1ps
// Summary of operation
// R01 - Host rings tail doorbell after adding commands
// R02 - Tail doorbell write replaces stored tail
// R03 - Fetch in queue order, execute any order
// R04 - Every command slot is 64 bytes
// R05 - Buffer described by two pointers or segment
// R06 - Long buffers use a pointer list
// R07 - Segment chain links each next segment
// R08 - Completion names queue and command identifier
// R09 - Several command rings share one result ring
// R10 - Host advances result head after consuming
// R11 - Phase marker flags newly posted entries
// R12 - Phase marker flips on each wrap
// R13 - Admin ring carries management commands only
// R14 - Admin rings always pair one to one; I/O rings may still name result ring 0
// R15 - Up to 65535 queues, 64K deep
// R16 - One register write submits commands
// R17 - No controller register reads needed
// R18 - Broadcast namespace identifier reports common settings
// R19 - One command set for all queue pairs
// R20 - Rings live in host memory, bus mastered
// R21 - Indices wrap; head equals tail is empty
module hqpe_engine
	import hqpe_pkg::*;
#(
	parameter int NUM_CR = 4,
	parameter int NUM_RS = 2,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic cfg_valid_i,
	input wire hqpe_qcfg_type cfg_i,
	input wire logic bell_valid_i,
	input wire hqpe_bell_type bell_i,
	output logic mem_rd_valid_o,
	input wire logic mem_rd_ready_i,
	output logic [ADDR_W-1:0] mem_rd_addr_o,
	input wire logic mem_rd_data_valid_i,
	output logic mem_rd_data_ready_o,
	input wire logic [DATA_W-1:0] mem_rd_data_i,
	output logic mem_wr_valid_o,
	input wire logic mem_wr_ready_i,
	output logic [ADDR_W-1:0] mem_wr_addr_o,
	output logic [CPL_W-1:0] mem_wr_data_o,
	output logic cmd_valid_o,
	input wire logic cmd_ready_i,
	output hqpe_beat_type cmd_o,
	input wire logic cpl_valid_i,
	output logic cpl_ready_o,
	input wire hqpe_cpl_type cpl_i
);
	localparam int SW = (NUM_CR > 1) ? $clog2(NUM_CR) : 1;
	localparam int CW = (NUM_RS > 1) ? $clog2(NUM_RS) : 1;
	localparam int BW = $clog2(BEATS_PER_CMD);
	localparam int FW = $clog2(DEPTH) + 1;
	localparam logic [FW-1:0] ROOM_MAX = FW'(DEPTH - BEATS_PER_CMD);
	localparam logic [BW-1:0] LAST_BEAT = BW'(BEATS_PER_CMD - 1);

	typedef enum {F_IDLE, F_REQ, F_BEAT} hqpe_fetch_type;
	typedef enum {C_IDLE, C_CHK, C_WR} hqpe_post_type;

	// Command ring state, one entry per ring
	logic [ADDR_W-1:0] cr_base_q [NUM_CR]; // Ring base address
	logic [IDX_W-1:0] cr_last_q [NUM_CR]; // Index of last slot
	logic [CW-1:0] cr_rs_q [NUM_CR]; // Associated result ring
	logic [IDX_W-1:0] cr_tail_q [NUM_CR]; // Tail, 16 bits cover 64K slots [R15]
	logic [IDX_W-1:0] cr_head_q [NUM_CR]; // Next slot to fetch
	logic [NUM_CR-1:0] cr_en_q; // Ring created
	logic [NUM_CR-1:0] cr_busy_w; // Ring holds unfetched commands

	// Result ring state, one entry per ring
	logic [ADDR_W-1:0] rs_base_q [NUM_RS]; // Ring base address
	logic [IDX_W-1:0] rs_last_q [NUM_RS]; // Index of last slot
	logic [IDX_W-1:0] rs_tail_q [NUM_RS]; // Next slot to post
	logic [IDX_W-1:0] rs_head_q [NUM_RS]; // Head from the doorbell
	logic [NUM_RS-1:0] rs_phase_q; // Phase marker for this pass
	logic [NUM_RS-1:0] rs_en_q; // Ring created

	// Fetch engine
	hqpe_fetch_type fstate_q;
	logic [SW-1:0] rr_q; // Ring currently offered the fetch slot
	logic [SW-1:0] fsel_q; // Ring being fetched
	logic [BW-1:0] beat_q; // Beat counter within a command
	logic rd_valid_q; // Read request pending
	logic [ADDR_W-1:0] rd_addr_q; // Read request address
	logic rd_ready_q; // Accepting read data
	logic fetch_done_w; // Last beat taken this cycle
	logic beat_take_w; // Read beat taken this cycle
	logic [FW-1:0] fifo_count_w;
	logic fifo_in_ready_w;
	logic fifo_out_valid_w;
	logic fifo_out_ready_w;
	hqpe_beat_type beat_w;
	hqpe_beat_type fifo_out_w;
	logic [IDX_W-1:0] fhead_w;
	logic [ADDR_W-1:0] fetch_addr_w;
	logic start_fetch_w;

	// Executor output stage
	logic cmd_valid_q;
	hqpe_beat_type cmd_q;

	// Completion poster
	hqpe_post_type cstate_q;
	hqpe_cpl_type cpl_q; // Completion being posted
	logic cpl_ready_q;
	logic cpl_take_w;
	logic [CW-1:0] csel_w; // Result ring for the held completion
	logic [IDX_W-1:0] ctail_w;
	logic [IDX_W-1:0] ctail_next_w;
	logic rs_full_w;
	logic wr_valid_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [CPL_W-1:0] wr_data_q;
	logic post_done_w; // Entry accepted by memory this cycle
	logic [CPL_W-1:0] entry_w;

	// Doorbell and creation decode
	logic bell_cr_w;
	logic bell_rs_w;
	logic cfg_cr_w;
	logic cfg_rs_w;

	// Doorbell writes are the only host action needed to submit [R16] [R17]
	assign bell_cr_w = bell_valid_i && !bell_i.is_result && (bell_i.qid < QID_W'(NUM_CR));
	assign bell_rs_w = bell_valid_i && bell_i.is_result && (bell_i.qid < QID_W'(NUM_RS));
	assign cfg_cr_w = cfg_valid_i && !cfg_i.is_result && (cfg_i.qid < QID_W'(NUM_CR));
	assign cfg_rs_w = cfg_valid_i && cfg_i.is_result && (cfg_i.qid < QID_W'(NUM_RS));

	// Per command ring bookkeeping
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CR; gi++) begin : g_cr
			// Ring empty when head equals tail [R21]
			assign cr_busy_w[gi] = cr_en_q[gi] && (cr_head_q[gi] != cr_tail_q[gi]);

			// Creation, doorbell and fetch progress
			always_ff @(posedge core_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					cr_en_q[gi] <= 1'b0;
					cr_base_q[gi] <= '0;
					cr_last_q[gi] <= '0;
					cr_rs_q[gi] <= '0;
					cr_tail_q[gi] <= '0;
					cr_head_q[gi] <= '0;
				end else if (cfg_cr_w && cfg_i.qid[SW-1:0] == SW'(gi)) begin
					cr_en_q[gi] <= 1'b1;
					cr_base_q[gi] <= cfg_i.base;
					cr_last_q[gi] <= cfg_i.last_slot;
					cr_tail_q[gi] <= '0;
					cr_head_q[gi] <= '0;
					// Admin ring is bound to the admin result ring [R14]
					if (QID_W'(gi) == ADMIN_QID) begin
						cr_rs_q[gi] <= '0;
					end else begin
						// Any I/O ring may name a shared result ring [R09]
						cr_rs_q[gi] <= cfg_i.result_qid[CW-1:0];
					end
				end else begin
					// New tail overwrites the old one [R02]
					if (bell_cr_w && bell_i.qid[SW-1:0] == SW'(gi)) begin
						cr_tail_q[gi] <= bell_i.value;
					end
					// Head steps one slot per fetched command, wrapping [R03] [R21]
					if (fetch_done_w && fsel_q == SW'(gi)) begin
						cr_head_q[gi] <= fhead_w;
					end
				end
			end
		end
	endgenerate

	// Per result ring bookkeeping
	generate
		for (gi = 0; gi < NUM_RS; gi++) begin : g_rs
			// Creation, host head updates and posting progress
			always_ff @(posedge core_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					rs_en_q[gi] <= 1'b0;
					rs_base_q[gi] <= '0;
					rs_last_q[gi] <= '0;
					rs_tail_q[gi] <= '0;
					rs_head_q[gi] <= '0;
					rs_phase_q[gi] <= PHASE_RESET;
				end else if (cfg_rs_w && cfg_i.qid[CW-1:0] == CW'(gi)) begin
					rs_en_q[gi] <= 1'b1;
					rs_base_q[gi] <= cfg_i.base;
					rs_last_q[gi] <= cfg_i.last_slot;
					rs_tail_q[gi] <= '0;
					rs_head_q[gi] <= '0;
					rs_phase_q[gi] <= PHASE_RESET;
				end else begin
					// Host frees entries by moving the head [R10]
					if (bell_rs_w && bell_i.qid[CW-1:0] == CW'(gi)) begin
						rs_head_q[gi] <= bell_i.value;
					end
					// Tail advances; phase flips on wrap [R12] [R21]
					if (post_done_w && csel_w == CW'(gi)) begin
						rs_tail_q[gi] <= ctail_next_w;
						if (ctail_w == rs_last_q[gi]) begin
							rs_phase_q[gi] <= ~rs_phase_q[gi];
						end
					end
				end
			end
		end
	endgenerate

	// Fetch address: ring base plus slot times the fixed command size [R04] [R20]
	assign fhead_w = (cr_head_q[fsel_q] == cr_last_q[fsel_q]) ? '0 : cr_head_q[fsel_q] + 1'b1;
	assign fetch_addr_w = cr_base_q[rr_q] + (ADDR_W'(cr_head_q[rr_q]) << CMD_SHIFT);
	// Start only when a whole command fits in the buffer
	assign start_fetch_w = (fstate_q == F_IDLE) && cr_busy_w[rr_q] && (fifo_count_w <= ROOM_MAX);
	assign beat_take_w = (fstate_q == F_BEAT) && rd_ready_q && mem_rd_data_valid_i;
	assign fetch_done_w = beat_take_w && (beat_q == LAST_BEAT);

	// Beat tagging; pointer words pass whole for the executor to follow [R05] [R06] [R07]
	assign beat_w.sqid = QID_W'(fsel_q);
	assign beat_w.first = (beat_q == '0);
	assign beat_w.last = (beat_q == LAST_BEAT);
	// Broadcast namespace request flagged on the first beat [R18]
	assign beat_w.bcast = (beat_q == '0) && (mem_rd_data_i[NSID_LSB +: 32] == NSID_BCAST);
	assign beat_w.data = mem_rd_data_i;

	// Fetch state machine, one command at a time in ring order [R03]
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fstate_q <= F_IDLE;
			rr_q <= '0;
			fsel_q <= '0;
			beat_q <= '0;
			rd_valid_q <= 1'b0;
			rd_addr_q <= '0;
			rd_ready_q <= 1'b0;
		end else begin
			case (fstate_q)
				F_IDLE: begin
					if (start_fetch_w) begin
						// Issue the read for the head slot
						fsel_q <= rr_q;
						rd_addr_q <= fetch_addr_w;
						rd_valid_q <= 1'b1;
						fstate_q <= F_REQ;
					end
					// Offer the slot to the next ring
					rr_q <= (rr_q == SW'(NUM_CR - 1)) ? '0 : rr_q + 1'b1;
				end
				F_REQ: begin
					// Wait for the memory to take the request
					if (mem_rd_ready_i) begin
						rd_valid_q <= 1'b0;
						rd_ready_q <= 1'b1;
						beat_q <= '0;
						fstate_q <= F_BEAT;
					end
				end
				F_BEAT: begin
					// Collect the beats of one command
					if (beat_take_w) begin
						beat_q <= beat_q + 1'b1;
						if (beat_q == LAST_BEAT) begin
							rd_ready_q <= 1'b0;
							fstate_q <= F_IDLE;
						end
					end
				end
				default: begin
					fstate_q <= F_IDLE;
				end
			endcase
		end
	end

	// Command buffer between memory and executor
	hqpe_fifo #(
		.WIDTH($bits(hqpe_beat_type)),
		.DEPTH(DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(beat_take_w),
		.in_ready_o(fifo_in_ready_w),
		.in_data_i(beat_w),
		.out_valid_o(fifo_out_valid_w),
		.out_ready_i(fifo_out_ready_w),
		.out_data_o(fifo_out_w),
		.count_o(fifo_count_w)
	);

	// Output stage refills when empty or when the executor takes a beat
	assign fifo_out_ready_w = !cmd_valid_q || cmd_ready_i;

	// Registered command output
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_valid_q <= 1'b0;
			cmd_q <= '0;
		end else if (fifo_out_ready_w) begin
			cmd_valid_q <= fifo_out_valid_w;
			cmd_q <= fifo_out_w;
		end
	end

	// Completion poster decode
	assign cpl_take_w = cpl_valid_i && cpl_ready_q;
	assign csel_w = cr_rs_q[cpl_q.sqid[SW-1:0]];
	assign ctail_w = rs_tail_q[csel_w];
	assign ctail_next_w = (ctail_w == rs_last_q[csel_w]) ? '0 : ctail_w + 1'b1;
	// Full when one more post would make tail meet head [R21]
	assign rs_full_w = !rs_en_q[csel_w] || (ctail_next_w == rs_head_q[csel_w]);
	assign post_done_w = (cstate_q == C_WR) && mem_wr_ready_i;

	// Entry: ring and command identifier pair, fetch head and phase [R08] [R11]
	always_comb begin
		entry_w = '0;
		entry_w[CPL_SQHD_LSB +: IDX_W] = cr_head_q[cpl_q.sqid[SW-1:0]];
		entry_w[CPL_SQID_LSB +: QID_W] = cpl_q.sqid;
		entry_w[CPL_CID_LSB +: 16] = cpl_q.cid;
		entry_w[CPL_PHASE_BIT] = rs_phase_q[csel_w];
		entry_w[CPL_STAT_LSB +: STAT_W] = cpl_q.status;
	end

	// Posting state machine, shared result rings take all sources [R09]
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cstate_q <= C_IDLE;
			cpl_q <= '0;
			cpl_ready_q <= 1'b0;
			wr_valid_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else begin
			case (cstate_q)
				C_IDLE: begin
					// Hold one completion at a time
					if (cpl_take_w) begin
						cpl_q <= cpl_i;
						cpl_ready_q <= 1'b0;
						cstate_q <= C_CHK;
					end else begin
						cpl_ready_q <= 1'b1;
					end
				end
				C_CHK: begin
					// Wait for room in the result ring
					if (!rs_full_w) begin
						wr_addr_q <= rs_base_q[csel_w] + (ADDR_W'(ctail_w) << CPL_SHIFT);
						wr_data_q <= entry_w;
						wr_valid_q <= 1'b1;
						cstate_q <= C_WR;
					end
				end
				C_WR: begin
					// Entry leaves to host memory [R20]
					if (mem_wr_ready_i) begin
						wr_valid_q <= 1'b0;
						cstate_q <= C_IDLE;
					end
				end
				default: begin
					cstate_q <= C_IDLE;
				end
			endcase
		end
	end

	// Port drive from registers
	assign mem_rd_valid_o = rd_valid_q;
	assign mem_rd_addr_o = rd_addr_q;
	assign mem_rd_data_ready_o = rd_ready_q;
	assign mem_wr_valid_o = wr_valid_q;
	assign mem_wr_addr_o = wr_addr_q;
	assign mem_wr_data_o = wr_data_q;
	assign cmd_valid_o = cmd_valid_q;
	assign cmd_o = cmd_q;
	assign cpl_ready_o = cpl_ready_q;
endmodule : hqpe_engine

//--- bench/hqpe_monitor.sv
`timescale 1ns/1ps
// Port-level checker for the queue pair engine
module hqpe_monitor
	import hqpe_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic mem_rd_valid_o,
	input wire logic mem_rd_ready_i,
	input wire logic [ADDR_W-1:0] mem_rd_addr_o,
	input wire logic mem_rd_data_valid_i,
	input wire logic mem_rd_data_ready_o,
	input wire logic mem_wr_valid_o,
	input wire logic mem_wr_ready_i,
	input wire logic [ADDR_W-1:0] mem_wr_addr_o,
	input wire logic [CPL_W-1:0] mem_wr_data_o,
	input wire logic cmd_valid_o,
	input wire logic cmd_ready_i,
	input wire hqpe_beat_type cmd_o,
	input wire logic cpl_valid_i,
	input wire logic cpl_ready_o,
	input wire hqpe_cpl_type cpl_i
);
	logic [2:0] rd_n_q; // Fetch beats taken within the slot
	logic [2:0] cmd_n_q; // Command beats handed out within the command
	logic [31:0] cpl_id_q; // Identity of the last accepted completion
	// Beat positions and completion identity for the checks below
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_n_q <= 3'h0;
			cmd_n_q <= 3'h0;
			cpl_id_q <= 32'h0;
		end else begin
			if (mem_rd_data_valid_i && mem_rd_data_ready_o) rd_n_q <= rd_n_q + 3'h1;
			if (cmd_valid_o && cmd_ready_i) cmd_n_q <= cmd_n_q + 3'h1;
			if (cpl_valid_i && cpl_ready_o) cpl_id_q <= {cpl_i.cid, cpl_i.sqid};
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_rd_hold; mem_rd_valid_o && !mem_rd_ready_i |=> mem_rd_valid_o && $stable(mem_rd_addr_o); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("fetch request not held");
	property p_rd_slot; mem_rd_valid_o |-> mem_rd_addr_o[5:0] == 6'h00; endproperty
	a_rd_slot: assert property (p_rd_slot) else $error("fetch address off a slot");
	property p_rd_take; mem_rd_valid_o && mem_rd_ready_i |=> !mem_rd_valid_o && mem_rd_data_ready_o; endproperty
	a_rd_take: assert property (p_rd_take) else $error("beats not taken after request");
	property p_rd_eight; mem_rd_data_valid_i && mem_rd_data_ready_o && rd_n_q == 3'h7 |=> !mem_rd_data_ready_o; endproperty
	a_rd_eight: assert property (p_rd_eight) else $error("slot not eight beats");
	property p_one_cmd; mem_rd_data_ready_o |-> !mem_rd_valid_o; endproperty
	a_one_cmd: assert property (p_one_cmd) else $error("fetch overlaps a fetch");
	property p_wr_hold; mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o && $stable(mem_wr_addr_o) && $stable(mem_wr_data_o); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("result write not held");
	property p_wr_slot; mem_wr_valid_o |-> mem_wr_addr_o[3:0] == 4'h0 && mem_wr_data_o[63:0] == 64'h0; endproperty
	a_wr_slot: assert property (p_wr_slot) else $error("result slot malformed");
	property p_wr_id; $rose(mem_wr_valid_o) |-> mem_wr_data_o[111:80] == cpl_id_q; endproperty
	a_wr_id: assert property (p_wr_id) else $error("result identity wrong");
	property p_cpl_drop; cpl_valid_i && cpl_ready_o |=> !cpl_ready_o; endproperty
	a_cpl_drop: assert property (p_cpl_drop) else $error("completion ready stayed up");
	property p_cmd_hold; cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_o); endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command beat not held");
	property p_cmd_mark; cmd_valid_o |-> cmd_o.first == (cmd_n_q == 3'h0) && cmd_o.last == (cmd_n_q == 3'h7); endproperty
	a_cmd_mark: assert property (p_cmd_mark) else $error("beat marks wrong");
	property p_bcast; cmd_valid_o |-> cmd_o.bcast == (cmd_o.first && cmd_o.data[63:32] == NSID_BCAST); endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");
	c_bcast: cover property (cmd_valid_o && cmd_o.bcast);
	c_rd_stall: cover property (mem_rd_valid_o && !mem_rd_ready_i);
	c_phase0: cover property (mem_wr_valid_o && !mem_wr_data_o[CPL_PHASE_BIT]);
endmodule : hqpe_monitor
bind hqpe_engine hqpe_monitor u_mon (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
	.mem_rd_valid_o(mem_rd_valid_o), .mem_rd_ready_i(mem_rd_ready_i), .mem_rd_addr_o(mem_rd_addr_o),
	.mem_rd_data_valid_i(mem_rd_data_valid_i), .mem_rd_data_ready_o(mem_rd_data_ready_o),
	.mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i), .mem_wr_addr_o(mem_wr_addr_o),
	.mem_wr_data_o(mem_wr_data_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
	.cmd_o(cmd_o), .cpl_valid_i(cpl_valid_i), .cpl_ready_o(cpl_ready_o), .cpl_i(cpl_i));

//--- bench/hqpe_host_mem.sv
`timescale 1ns/1ps
// Host memory holding the rings; answers fetches and result writes
module hqpe_host_mem
	import hqpe_pkg::*;
#(
	parameter logic [ADDR_W-1:0] BCAST_ADDR = 64'h00000000000000C0
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic slow_i,
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic rd_dv_o,
	input wire logic rd_take_i,
	output logic [DATA_W-1:0] rd_data_o,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic [CPL_W-1:0] wr_data_i
);
	logic [ADDR_W+CPL_W-1:0] wr_log [$]; // Result writes, address above entry
	logic tick_q; // Halves the answer rate when slow
	logic [3:0] left_q; // Beats still owed for the fetched slot
	logic [ADDR_W-1:0] addr_q; // Slot being returned
	logic go;
	logic taken;
	logic [3:0] rem;
	assign go = !slow_i || tick_q;
	assign taken = rd_dv_o && rd_take_i;
	assign rem = left_q - {3'h0, taken};
	// Slot contents follow the address; one slot carries the broadcast id
	function automatic logic [DATA_W-1:0] beat_val(input logic [ADDR_W-1:0] a, input logic [3:0] k);
		beat_val = {(a == BCAST_ADDR && k == 4'h0) ? NSID_BCAST : {16'hA5A5, a[15:0]}, 28'h0, k};
	endfunction : beat_val
	// Idle data lines toggle every cycle between the last beat and its inverse
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_q <= 1'b0;
			rd_ready_o <= 1'b0;
			rd_dv_o <= 1'b0;
			rd_data_o <= 64'h0;
			left_q <= 4'h0;
			addr_q <= 64'h0;
			wr_ready_o <= 1'b0;
		end else begin
			tick_q <= !tick_q;
			rd_ready_o <= rd_valid_i && !rd_ready_o && go;
			if (rd_valid_i && rd_ready_o) begin
				addr_q <= rd_addr_i;
				left_q <= 4'h8;
			end else begin
				left_q <= rem;
			end
			rd_dv_o <= (rd_dv_o && !taken) || (rem != 4'h0 && go);
			if (!(rd_dv_o && !taken)) begin
				rd_data_o <= (rem != 4'h0 && go) ? beat_val(addr_q, 4'h8 - rem) : ~rd_data_o;
			end
			wr_ready_o <= wr_valid_i && !wr_ready_o && go;
			if (wr_valid_i && wr_ready_o) wr_log.push_back({wr_addr_i, wr_data_i});
		end
	end
endmodule : hqpe_host_mem

//--- bench/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the queue pair engine
module testbench;
	import hqpe_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cfg_valid = 1'b0;
	hqpe_qcfg_type cfg = '0;
	logic bell_valid = 1'b0;
	hqpe_bell_type bell = '0;
	logic rd_valid, rd_ready, dv, take, wr_valid, wr_ready, cmd_valid, cpl_ready;
	logic [ADDR_W-1:0] rd_addr, wr_addr;
	logic [DATA_W-1:0] rd_data;
	logic [CPL_W-1:0] wr_data;
	logic cmd_ready = 1'b0;
	logic cpl_valid = 1'b0;
	logic slow = 1'b0;
	hqpe_beat_type cmd;
	hqpe_cpl_type cpl = '0;
	hqpe_beat_type beat_q [$]; // Command beats handed out
	logic [ADDR_W-1:0] rd_q [$]; // Slot addresses fetched
	int n_fail = 0;
	int check_count = 0;
	always #50 core_clk = !core_clk;
	hqpe_engine dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .cfg_valid_i(cfg_valid), .cfg_i(cfg),
		.bell_valid_i(bell_valid), .bell_i(bell), .mem_rd_valid_o(rd_valid),
		.mem_rd_ready_i(rd_ready), .mem_rd_addr_o(rd_addr), .mem_rd_data_valid_i(dv),
		.mem_rd_data_ready_o(take), .mem_rd_data_i(rd_data), .mem_wr_valid_o(wr_valid),
		.mem_wr_ready_i(wr_ready), .mem_wr_addr_o(wr_addr), .mem_wr_data_o(wr_data),
		.cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready), .cmd_o(cmd), .cpl_valid_i(cpl_valid),
		.cpl_ready_o(cpl_ready), .cpl_i(cpl));
	hqpe_host_mem mdl (.core_clk_i(core_clk), .rst_b_i(rst_b), .slow_i(slow), .rd_valid_i(rd_valid),
		.rd_ready_o(rd_ready), .rd_addr_i(rd_addr), .rd_dv_o(dv), .rd_take_i(take),
		.rd_data_o(rd_data), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_addr_i(wr_addr),
		.wr_data_i(wr_data));
	// Log accepted fetches and delivered beats
	always @(posedge core_clk) begin
		if (rd_valid && rd_ready) rd_q.push_back(rd_addr);
		if (cmd_valid && cmd_ready) beat_q.push_back(cmd);
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [CPL_W-1:0] e, input logic [CPL_W-1:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Bounded wait: 0 beats, 1 fetches, 2 result writes, 3 never met
	task automatic wait_n(input int kind, input int n);
		int sz;
		for (int i = 0; i < 3000; i++) begin
			sz = kind == 0 ? beat_q.size() : kind == 1 ? rd_q.size() : kind == 2 ? mdl.wr_log.size() : 0;
			if (sz >= n) return;
			@(negedge core_clk);
		end
		n_fail++;
		$display("[FAIL] wait %0d expected %0d seen %0d", kind, n, sz);
		end_of_test();
	endtask : wait_n
	task automatic create(input logic r, input logic [15:0] q, input logic [ADDR_W-1:0] b,
		input logic [15:0] last, input logic [15:0] rq);
		@(negedge core_clk);
		cfg = '{r, q, b, last, rq};
		cfg_valid = 1'b1;
		@(negedge core_clk);
		cfg_valid = 1'b0;
	endtask : create
	task automatic ring(input logic r, input logic [15:0] q, input logic [15:0] v);
		@(negedge core_clk);
		bell = '{r, q, v};
		bell_valid = 1'b1;
		@(negedge core_clk);
		bell_valid = 1'b0;
	endtask : ring
	// One fetched slot: its address and its eight beats in order
	task automatic chk_cmd(input logic [15:0] cr, input logic [ADDR_W-1:0] a);
		hqpe_beat_type e;
		wait_n(0, BEATS_PER_CMD);
		chk("fetch address", a, rd_q.pop_front());
		for (int k = 0; k < BEATS_PER_CMD; k++) begin
			e = '{cr, k == 0, k == BEATS_PER_CMD - 1, 1'b0, mdl.beat_val(a, 4'(k))};
			e.bcast = e.first && e.data[63:32] == NSID_BCAST;
			chk("command beat", e, beat_q.pop_front());
		end
	endtask : chk_cmd
	function automatic logic [CPL_W-1:0] ent(input logic [14:0] st, input logic ph,
		input logic [15:0] cid, input logic [15:0] cr, input logic [15:0] hd);
		ent = {st, ph, cid, cr, hd, 64'h0};
	endfunction : ent
	task automatic chk_wr(input logic [ADDR_W-1:0] a, input logic [CPL_W-1:0] e);
		logic [ADDR_W+CPL_W-1:0] lg;
		wait_n(2, 1);
		lg = mdl.wr_log.pop_front();
		chk("result address", a, lg[ADDR_W+CPL_W-1:CPL_W]);
		chk("result entry", e, lg[CPL_W-1:0]);
	endtask : chk_wr
	// Completion held until ready is seen at a rising edge
	task automatic post(input logic [15:0] cr, input logic [15:0] cid, input logic [14:0] st);
		int i;
		@(negedge core_clk);
		cpl = '{cr, cid, st};
		cpl_valid = 1'b1;
		for (i = 0; i < 3000 && cpl_ready !== 1'b1; i++) @(negedge core_clk);
		if (i == 3000) wait_n(3, 1);
		@(negedge core_clk);
		cpl_valid = 1'b0;
	endtask : post
	// Stalled consumer: buffer refuses a third slot, then drains in order
	task automatic s_fill();
		slow = 1'b1;
		@(negedge core_clk);
		bell = '{1'b0, 16'h0, 16'h2};
		bell_valid = 1'b1;
		@(negedge core_clk);
		bell.value = 16'h3;
		@(negedge core_clk);
		bell_valid = 1'b0;
		wait_n(1, 2);
		repeat (60) @(negedge core_clk);
		chk("fetches while full", 2, rd_q.size());
		chk("stalled valid", 1, cmd_valid);
		cmd_ready = 1'b1;
		chk_cmd(0, 64'h0);
		chk_cmd(0, 64'h40);
		chk_cmd(0, 64'h80);
		slow = 1'b0;
	endtask : s_fill
	// Tail behind head: last slot then slot zero, broadcast slot flagged
	task automatic s_wrap();
		ring(0, 0, 1);
		chk_cmd(0, 64'hC0);
		chk_cmd(0, 64'h0);
		ring(0, 1, 1);
		chk_cmd(1, 64'h400);
	endtask : s_wrap
	// Shared result ring: fill, refuse, free, wrap with phase flip
	task automatic s_results();
		slow = 1'b1;
		post(0, 16'h11, 15'h0001);
		post(1, 16'h22, 15'h7FFF);
		chk_wr(64'h1000, ent(15'h0001, 1'b1, 16'h11, 16'h0, 16'h1));
		chk_wr(64'h1010, ent(15'h7FFF, 1'b1, 16'h22, 16'h1, 16'h1));
		post(0, 16'h33, 15'h0000);
		repeat (40) @(negedge core_clk);
		chk("write into full ring", 0, mdl.wr_log.size());
		ring(1, 0, 2);
		chk_wr(64'h1020, ent(15'h0000, 1'b1, 16'h33, 16'h0, 16'h1));
		post(1, 16'h44, 15'h0002);
		chk_wr(64'h1000, ent(15'h0002, 1'b0, 16'h44, 16'h1, 16'h1));
	endtask : s_results
	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		rst_b = 1'b1;
		create(1, 0, 64'h1000, 2, 0);
		create(1, 1, 64'h2000, 3, 0);
		create(0, 0, 64'h0, 3, 1);
		create(0, 1, 64'h400, 3, 0);
		s_fill();
		s_wrap();
		s_results();
		end_of_test();
	end
endmodule : testbench
